// ---- verilog/mos_defines.svh ----
`ifndef MOS_DEFINES_SVH
`define MOS_DEFINES_SVH
// Register offsets
`define MOS_REG_SLEEP_CFG 8'h0e
`define MOS_REG_BRAKE_CFG 8'h13
`define MOS_REG_DC_CFG 8'h14
`define MOS_REG_FC_CFG 8'h15
`define MOS_REG_HYS_CFG 8'h18
`define MOS_REG_COUNT 3'h5
// Register reset values, overwritten by the load from memory
`define MOS_RST_CFG 8'h00
// Released sleep pin level, normal operation
`define MOS_PIN_IDLE 1'b1
// Field positions
`define MOS_SLEEP_SEL_BIT 7
`define MOS_BRAKE_TIME_HI 7
`define MOS_BRAKE_TIME_LO 5
`define MOS_BRAKE_MODE_BIT 4
`define MOS_BRAKE_HOLD_BIT 3
`define MOS_DC1_HI 4
`define MOS_DC1_LO 3
`define MOS_DC2_HI 2
`define MOS_DC2_LO 0
`define MOS_FC_HI 1
`define MOS_FC_LO 0
`define MOS_HYS_HI 7
`define MOS_HYS_LO 6
// Clock rate in Hz; times in milliseconds
`define MOS_CLK_HZ 25000000
`define MOS_MS_PER_S 1000
`define MOS_SLEEP_QUAL_MS 13'h0064
`define MOS_BRAKE_STEP_MS 13'h03e8
`define MOS_DC1_T0 13'h0000
`define MOS_DC1_T1 13'h00c8
`define MOS_DC1_T2 13'h01f4
`define MOS_DC1_T3 13'h03e8
`define MOS_DC2_T0 13'h0064
`define MOS_DC2_T1 13'h00c8
`define MOS_DC2_T2 13'h0190
`define MOS_DC2_T3 13'h0258
`define MOS_DC2_T4 13'h0320
`define MOS_DC2_T5 13'h03e8
`define MOS_DC2_T6 13'h05dc
`define MOS_DC2_T7 13'h07d0
`define MOS_WIN_T0 13'h00c8
`define MOS_WIN_T1 13'h0064
`define MOS_WIN_T2 13'h0032
`define MOS_WIN_T3 13'h0019
`define MOS_RESTART_MS 1000
`define MOS_ZERO_MS 13'h0000
`define MOS_ONE_MS 13'h0001
`define MOS_TMR_MAX 13'h1fff
`endif

// ---- verilog/mos_pkg.sv ----
package mos_pkg;
  typedef enum logic [3:0] {
    MOS_LOAD = 4'h0,
    MOS_BRAKE = 4'h1,
    MOS_HOLD = 4'h2,
    MOS_IDLE = 4'h3,
    MOS_DETECT = 4'h4,
    MOS_DC1 = 4'h5,
    MOS_DC2 = 4'h6,
    MOS_FORCED = 4'h7,
    MOS_RUN = 4'h8,
    MOS_ERROR = 4'h9,
    MOS_SLEEP = 4'ha
  } mos_state_t;
  typedef enum logic [2:0] {
    MOS_DRV_OFF = 3'h0,
    MOS_DRV_BRAKE = 3'h1,
    MOS_DRV_DC1 = 3'h2,
    MOS_DRV_DC2 = 3'h3,
    MOS_DRV_FORCED = 3'h4,
    MOS_DRV_SENSORLESS = 3'h5
  } mos_drive_t;
endpackage : mos_pkg

// ---- verilog/mos_sequencer.sv ----
`timescale 1ns/1ns
`include "mos_defines.svh"
module mos_sequencer #(
  parameter int MS_CYCLES = `MOS_CLK_HZ / `MOS_MS_PER_S,
  parameter int RESTART_MS = `MOS_RESTART_MS
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic sleep_request_pin_i,
  input wire logic [7:0] speed_cmd_i,
  input wire logic fault_i,
  input wire logic motor_forward_i,
  input wire logic sensorless_ready_i,
  input wire logic max_speed_off_setting_i,
  input wire logic never_halt_setting_i,
  input wire logic speed_inversion_setting_i,
  output logic nvm_req_o,
  output logic [7:0] nvm_addr_o,
  input wire logic nvm_ack_i,
  input wire logic [7:0] nvm_data_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic [3:0] state_o,
  output logic [2:0] drive_mode_o,
  output logic gates_hiz_o,
  output logic error_clear_o,
  output logic [1:0] forced_commutation_freq_o,
  output logic [1:0] position_comparator_hysteresis_o
);

  // Pin synchroniser; the first stage feeds only the second. It resets to the
  // released level, so leaving reset never fakes a sleep request
  logic pin_meta_r;
  logic pin_sync_r;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_meta_r <= `MOS_PIN_IDLE;
      pin_sync_r <= `MOS_PIN_IDLE;
    end else begin
      pin_meta_r <= sleep_request_pin_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Setting registers
  logic [7:0] sleep_cfg_r;
  logic [7:0] brake_cfg_r;
  logic [7:0] dc_cfg_r;
  logic [7:0] fc_cfg_r;
  logic [7:0] hys_cfg_r;
  logic [7:0] rdata_r;
  mos_pkg::mos_state_t state_r;
  mos_pkg::mos_state_t state_nxt;

  // Load sequencing: index over the five setting offsets
  logic [2:0] load_idx_r;
  logic load_done;
  logic [7:0] load_addr;
  assign load_done = (load_idx_r == `MOS_REG_COUNT);
  assign load_addr = (load_idx_r == 3'h0) ? `MOS_REG_SLEEP_CFG :
                     (load_idx_r == 3'h1) ? `MOS_REG_BRAKE_CFG :
                     (load_idx_r == 3'h2) ? `MOS_REG_DC_CFG :
                     (load_idx_r == 3'h3) ? `MOS_REG_FC_CFG : `MOS_REG_HYS_CFG;

  // One write source at a time: memory load while loading, port otherwise
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic load_wr;
  assign load_wr = (state_r == mos_pkg::MOS_LOAD) && !load_done && nvm_ack_i;
  assign wr_en = load_wr || (reg_wr_i && state_r != mos_pkg::MOS_LOAD);
  assign wr_addr = load_wr ? load_addr : reg_addr_i;
  assign wr_data = load_wr ? nvm_data_i : reg_wdata_i;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sleep_cfg_r <= `MOS_RST_CFG;
      brake_cfg_r <= `MOS_RST_CFG;
      dc_cfg_r <= `MOS_RST_CFG;
      fc_cfg_r <= `MOS_RST_CFG;
      hys_cfg_r <= `MOS_RST_CFG;
    end else if (wr_en) begin
      if (wr_addr == `MOS_REG_SLEEP_CFG) sleep_cfg_r <= wr_data;
      if (wr_addr == `MOS_REG_BRAKE_CFG) brake_cfg_r <= wr_data;
      if (wr_addr == `MOS_REG_DC_CFG) dc_cfg_r <= wr_data;
      if (wr_addr == `MOS_REG_FC_CFG) fc_cfg_r <= wr_data;
      if (wr_addr == `MOS_REG_HYS_CFG) hys_cfg_r <= wr_data;
    end
  end

  // Load index advances per acknowledged word; held at zero in every state other than load
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      load_idx_r <= 3'h0;
    end else if (state_r != mos_pkg::MOS_LOAD) begin
      load_idx_r <= 3'h0;
    end else if (load_wr) begin
      load_idx_r <= load_idx_r + 3'h1;
    end
  end
  assign nvm_req_o = (state_r == mos_pkg::MOS_LOAD) && !load_done && pin_sync_r;
  assign nvm_addr_o = load_addr;

  // Read back; unmapped offsets read zero
  logic [7:0] rd_mux;
  assign rd_mux = (reg_addr_i == `MOS_REG_SLEEP_CFG) ? sleep_cfg_r :
                  (reg_addr_i == `MOS_REG_BRAKE_CFG) ? brake_cfg_r :
                  (reg_addr_i == `MOS_REG_DC_CFG) ? dc_cfg_r :
                  (reg_addr_i == `MOS_REG_FC_CFG) ? fc_cfg_r :
                  (reg_addr_i == `MOS_REG_HYS_CFG) ? hys_cfg_r : 8'h00;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= `MOS_RST_CFG;
    end else if (reg_rd_i) begin
      rdata_r <= rd_mux;
    end
  end
  assign reg_rdata_o = rdata_r;

  // Millisecond tick; every time below is counted in these ticks
  logic [14:0] pre_r;
  logic ms_tick;
  assign ms_tick = (pre_r == 15'(MS_CYCLES - 1));
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_r <= 15'h0000;
    end else begin
      pre_r <= ms_tick ? 15'h0000 : pre_r + 15'h0001;
    end
  end

  // Field decode into durations
  logic speed_zero;
  logic [2:0] brake_code;
  logic [12:0] brake_ms;
  logic brake_hold;
  logic [12:0] first_excitation_period;
  logic [12:0] second_excitation_period;
  logic [12:0] idle_window_ms;
  logic [12:0] restart_ms;
  assign speed_zero = (speed_cmd_i == 8'h00);
  assign brake_code = brake_cfg_r[`MOS_BRAKE_TIME_HI:`MOS_BRAKE_TIME_LO];
  assign brake_ms = 13'({10'h000, brake_code} * `MOS_BRAKE_STEP_MS);
  assign brake_hold = brake_cfg_r[`MOS_BRAKE_HOLD_BIT];
  assign restart_ms = 13'(RESTART_MS);
  always_comb begin
    case (dc_cfg_r[`MOS_DC1_HI:`MOS_DC1_LO])
      2'h0: first_excitation_period = `MOS_DC1_T0;
      2'h1: first_excitation_period = `MOS_DC1_T1;
      2'h2: first_excitation_period = `MOS_DC1_T2;
      default: first_excitation_period = `MOS_DC1_T3;
    endcase
  end
  always_comb begin
    case (dc_cfg_r[`MOS_DC2_HI:`MOS_DC2_LO])
      3'h0: second_excitation_period = `MOS_DC2_T0;
      3'h1: second_excitation_period = `MOS_DC2_T1;
      3'h2: second_excitation_period = `MOS_DC2_T2;
      3'h3: second_excitation_period = `MOS_DC2_T3;
      3'h4: second_excitation_period = `MOS_DC2_T4;
      3'h5: second_excitation_period = `MOS_DC2_T5;
      3'h6: second_excitation_period = `MOS_DC2_T6;
      default: second_excitation_period = `MOS_DC2_T7;
    endcase
  end
  always_comb begin
    case (fc_cfg_r[`MOS_FC_HI:`MOS_FC_LO])
      2'h0: idle_window_ms = `MOS_WIN_T0;
      2'h1: idle_window_ms = `MOS_WIN_T1;
      2'h2: idle_window_ms = `MOS_WIN_T2;
      default: idle_window_ms = `MOS_WIN_T3;
    endcase
  end

  // Sleep condition and its qualification
  logic refuse_sleep;
  logic sleep_cond;
  logic [12:0] qual_r;
  logic sleep_go;
  assign refuse_sleep = max_speed_off_setting_i | never_halt_setting_i
                        | speed_inversion_setting_i;
  assign sleep_cond = !pin_sync_r && (!sleep_cfg_r[`MOS_SLEEP_SEL_BIT]
                      || (speed_zero && !refuse_sleep));
  // One tick extra, since the first tick may land right after the condition rises
  assign sleep_go = sleep_cond && (qual_r > `MOS_SLEEP_QUAL_MS);
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      qual_r <= `MOS_ZERO_MS;
    end else if (!sleep_cond) begin
      qual_r <= `MOS_ZERO_MS;
    end else if (ms_tick && !sleep_go) begin
      qual_r <= qual_r + `MOS_ONE_MS;
    end
  end

  // State timer in ms, cleared on every state change
  logic [12:0] tmr_r;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tmr_r <= `MOS_ZERO_MS;
    end else if (state_nxt != state_r) begin
      tmr_r <= `MOS_ZERO_MS;
    end else if (ms_tick && tmr_r != `MOS_TMR_MAX) begin
      tmr_r <= tmr_r + `MOS_ONE_MS;
    end
  end

  // Operating state machine; sleep entry has top priority
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      mos_pkg::MOS_LOAD: begin
        if (!pin_sync_r) state_nxt = mos_pkg::MOS_SLEEP;
        else if (load_done) state_nxt = mos_pkg::MOS_BRAKE;
      end
      mos_pkg::MOS_BRAKE: begin
        if (tmr_r >= brake_ms) begin
          if (brake_hold && brake_ms != `MOS_ZERO_MS) state_nxt = mos_pkg::MOS_HOLD;
          else state_nxt = mos_pkg::MOS_IDLE;
        end
      end
      mos_pkg::MOS_HOLD: begin
        if (!speed_zero) state_nxt = mos_pkg::MOS_DETECT;
      end
      mos_pkg::MOS_IDLE: begin
        if (!speed_zero) state_nxt = mos_pkg::MOS_DETECT;
      end
      mos_pkg::MOS_DETECT: begin
        if (motor_forward_i) state_nxt = mos_pkg::MOS_RUN;
        else if (tmr_r >= idle_window_ms) state_nxt = mos_pkg::MOS_DC1;
      end
      mos_pkg::MOS_DC1: begin
        if (tmr_r >= first_excitation_period) state_nxt = mos_pkg::MOS_DC2;
      end
      mos_pkg::MOS_DC2: begin
        if (tmr_r >= second_excitation_period) state_nxt = mos_pkg::MOS_FORCED;
      end
      mos_pkg::MOS_FORCED: begin
        if (sensorless_ready_i) state_nxt = mos_pkg::MOS_RUN;
      end
      mos_pkg::MOS_RUN: begin
        state_nxt = mos_pkg::MOS_RUN;
      end
      mos_pkg::MOS_ERROR: begin
        if (speed_zero) state_nxt = mos_pkg::MOS_IDLE;
        else if (tmr_r >= restart_ms) state_nxt = mos_pkg::MOS_DETECT;
      end
      mos_pkg::MOS_SLEEP: begin
        if (!sleep_cond) state_nxt = mos_pkg::MOS_LOAD;
      end
      default: state_nxt = mos_pkg::MOS_LOAD;
    endcase
    // Shared exits of the detect, excitation, forced and run states
    if (state_r inside {mos_pkg::MOS_DETECT, mos_pkg::MOS_DC1, mos_pkg::MOS_DC2,
                        mos_pkg::MOS_FORCED, mos_pkg::MOS_RUN}) begin
      if (speed_zero) state_nxt = mos_pkg::MOS_IDLE;
      else if (fault_i) state_nxt = mos_pkg::MOS_ERROR;
    end
    if (state_r != mos_pkg::MOS_LOAD && state_r != mos_pkg::MOS_SLEEP && sleep_go) begin
      state_nxt = mos_pkg::MOS_SLEEP;
    end
  end

  // Drive mode as a function of the state being entered
  function automatic mos_pkg::mos_drive_t mos_drive_of(input mos_pkg::mos_state_t s,
                                                       input logic brake_short);
    case (s)
      mos_pkg::MOS_BRAKE, mos_pkg::MOS_HOLD:
        mos_drive_of = brake_short ? mos_pkg::MOS_DRV_BRAKE : mos_pkg::MOS_DRV_OFF;
      mos_pkg::MOS_DC1: mos_drive_of = mos_pkg::MOS_DRV_DC1;
      mos_pkg::MOS_DC2: mos_drive_of = mos_pkg::MOS_DRV_DC2;
      mos_pkg::MOS_FORCED: mos_drive_of = mos_pkg::MOS_DRV_FORCED;
      mos_pkg::MOS_RUN: mos_drive_of = mos_pkg::MOS_DRV_SENSORLESS;
      default: mos_drive_of = mos_pkg::MOS_DRV_OFF;
    endcase
  endfunction : mos_drive_of

  mos_pkg::mos_drive_t drive_r;
  logic err_clr_r;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= mos_pkg::MOS_LOAD;
      drive_r <= mos_pkg::MOS_DRV_OFF;
      err_clr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      drive_r <= mos_drive_of(state_nxt, brake_cfg_r[`MOS_BRAKE_MODE_BIT]);
      err_clr_r <= (state_nxt == mos_pkg::MOS_SLEEP);
    end
  end

  // Off covers load, idle, detect, error, sleep and a high-impedance brake or hold
  assign gates_hiz_o = (drive_r == mos_pkg::MOS_DRV_OFF);
  assign drive_mode_o = drive_r;
  assign error_clear_o = err_clr_r;
  assign state_o = state_r;
  assign forced_commutation_freq_o = fc_cfg_r[`MOS_FC_HI:`MOS_FC_LO];
  assign position_comparator_hysteresis_o = hys_cfg_r[`MOS_HYS_HI:`MOS_HYS_LO];

endmodule : mos_sequencer

// ---- test/mos_nvm_model.sv ----
`timescale 1ns/1ns
// Stored-settings memory answering load requests after a random wait
module mos_nvm_model (
  input wire logic clock_i,
  input wire logic req_i,
  input wire logic [7:0] addr_i,
  output logic ack_o,
  output logic [7:0] data_o
);
  logic [7:0] mem [0:255];
  int wait_n = 0;
  initial begin
    ack_o = 1'b0;
    data_o = 8'h00;
  end
  // Data is inverted outside ack so a stale byte never looks right
  always @(posedge clock_i) begin
    if (ack_o || !req_i) begin
      ack_o <= 1'b0;
      data_o <= ~data_o;
      wait_n <= $urandom % 4;
    end else if (wait_n == 0) begin
      ack_o <= 1'b1;
      data_o <= mem[addr_i];
    end else begin
      wait_n <= wait_n - 1;
      data_o <= ~data_o;
    end
  end
endmodule : mos_nvm_model

// ---- test/mos_sequencer_assertions.sv ----
`timescale 1ns/1ns
// State codes as plain literals: 3 idle, 4..8 startup to run, 9 error, a sleep
module mos_sequencer_assertions (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic sleep_request_pin_i,
  input wire logic [7:0] speed_cmd_i,
  input wire logic fault_i,
  input wire logic motor_forward_i,
  input wire logic nvm_req_o,
  input wire logic [7:0] nvm_addr_o,
  input wire logic nvm_ack_i,
  input wire logic [3:0] state_o,
  input wire logic [2:0] drive_mode_o,
  input wire logic gates_hiz_o,
  input wire logic error_clear_o
);
  logic pin_q1_r;
  logic pin_q2_r;
  wire go = speed_cmd_i != 8'h00;
  wire pin_ok = sleep_request_pin_i && pin_q1_r && pin_q2_r;
  wire busy = state_o inside {[4'h4:4'h8]};
  // Pin history, so a request still in the synchroniser is not missed
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_q1_r <= 1'b0;
      pin_q2_r <= 1'b0;
    end else begin
      pin_q1_r <= sleep_request_pin_i;
      pin_q2_r <= pin_q1_r;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  hiz_track_a: assert property (gates_hiz_o == (drive_mode_o == 3'h0))
    else $error("hiz flag disagrees with drive mode");
  sleep_off_a: assert property (error_clear_o == (state_o == 4'ha))
    else $error("error clear not tied to sleep");
  idle_off_a: assert property (state_o inside {4'h3, 4'ha} |-> gates_hiz_o)
    else $error("gates driven in idle or sleep");
  run_drive_a: assert property (state_o == 4'h8 |-> drive_mode_o == 3'h5)
    else $error("run without sensorless drive");
  stop_idle_a: assert property (busy && !go && pin_ok |=> state_o == 4'h3)
    else $error("stop command did not reach idle");
  fault_err_a: assert property (busy && go && fault_i && pin_ok |=> state_o == 4'h9)
    else $error("fault did not enter error");
  err_stop_a: assert property (state_o == 4'h9 && !go && pin_ok |=> state_o == 4'h3)
    else $error("stop in error did not reach idle");
  fwd_run_a: assert property (state_o == 4'h4 && motor_forward_i && go && !fault_i
    && pin_ok |=> state_o == 4'h8)
    else $error("forward idling did not skip to run");
  excite_drive_a: assert property (state_o inside {[4'h5:4'h7]}
    |-> drive_mode_o == (state_o == 4'h5 ? 3'h2 : state_o == 4'h6 ? 3'h3 : 3'h4))
    else $error("excitation or forced step with wrong drive");
  addr_hold_a: assert property (nvm_req_o && !nvm_ack_i |=> $stable(nvm_addr_o))
    else $error("load offset moved without ack");
endmodule : mos_sequencer_assertions

// ---- test/tb_mos_sequencer.sv ----
`timescale 1ns/1ns
module tb_mos_sequencer;
  localparam int MS = 4;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic pin = 1'b1, flt = 1'b0, fwd = 1'b0, rdy = 1'b0, halt = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] spd = 8'h00, addr = 8'h00, wdat = 8'h00;
  logic req, ack, hiz, eclr;
  logic [7:0] naddr, ndat, rdat;
  logic [3:0] st;
  logic [2:0] drv;
  logic [1:0] fcf, hys;
  logic [7:0] mdl [logic [7:0]];
  logic [7:0] al [6] = '{8'h0e, 8'h13, 8'h14, 8'h15, 8'h18, 8'h20};
  int err_count = 0;
  int check_count = 0;
  always #20 clock_i = ~clock_i;
  mos_sequencer #(.MS_CYCLES(MS), .RESTART_MS(5)) i_mos_sequencer (
    .clock_i(clock_i), .resetn_i(resetn_i), .sleep_request_pin_i(pin), .speed_cmd_i(spd),
    .fault_i(flt), .motor_forward_i(fwd), .sensorless_ready_i(rdy),
    .max_speed_off_setting_i(1'b0), .never_halt_setting_i(halt),
    .speed_inversion_setting_i(1'b0), .nvm_req_o(req), .nvm_addr_o(naddr), .nvm_ack_i(ack),
    .nvm_data_i(ndat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdat),
    .reg_rdata_o(rdat), .state_o(st), .drive_mode_o(drv), .gates_hiz_o(hiz),
    .error_clear_o(eclr), .forced_commutation_freq_o(fcf),
    .position_comparator_hysteresis_o(hys));
  mos_nvm_model i_mos_nvm_model (.clock_i(clock_i), .req_i(req), .addr_i(naddr),
    .ack_o(ack), .data_o(ndat));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Memory and bench register mirror are set together
  task automatic setm(input logic [7:0] a, input logic [7:0] v);
    i_mos_nvm_model.mem[a] = v;
    mdl[a] = v;
  endtask : setm
  task automatic wait_st(input logic [3:0] s);
    int n;
    n = 0;
    while (st !== s && n < 400) begin
      @(negedge clock_i);
      n++;
    end
    chk(st, s);
  endtask : wait_st
  // Millisecond ticks run free, so one tick of slack either way
  task automatic measure(input logic [3:0] s, input int ms);
    int n;
    n = 0;
    while (st === s && n < (ms + 2) * MS) begin
      @(negedge clock_i);
      n++;
    end
    chk(n >= (ms - 1) * MS && n <= (ms + 1) * MS + 3, 1'b1);
  endtask : measure
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_i);
    rd <= 1'b0;
    @(negedge clock_i);
    chk(rdat, mdl.exists(a) ? mdl[a] : 8'h00);
  endtask : rd_reg
  task automatic go(input logic [7:0] v);
    @(posedge clock_i);
    spd <= v;
  endtask : go
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    #(24000 * 40);
    err_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hbf45e745));
    setm(8'h0e, 8'h00);
    setm(8'h13, 8'h30);
    setm(8'h14, 8'h08);
    setm(8'h15, 8'h02);
    setm(8'h18, 8'hc0);
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    wait_st(mos_pkg::MOS_BRAKE);
    chk(drv, mos_pkg::MOS_DRV_BRAKE);
    measure(mos_pkg::MOS_BRAKE, 1000);
    wait_st(mos_pkg::MOS_IDLE);
    for (int i = 0; i < 6; i++) rd_reg(al[i]);
    chk(fcf, 2'h2);
    chk(hys, 2'h3);
    go(8'($urandom_range(255, 1)));
    wait_st(mos_pkg::MOS_DETECT);
    measure(mos_pkg::MOS_DETECT, 50);
    chk(drv, mos_pkg::MOS_DRV_DC1);
    measure(mos_pkg::MOS_DC1, 200);
    chk(drv, mos_pkg::MOS_DRV_DC2);
    measure(mos_pkg::MOS_DC2, 100);
    chk({st, drv}, {mos_pkg::MOS_FORCED, mos_pkg::MOS_DRV_FORCED});
    @(posedge clock_i);
    rdy <= 1'b1;
    wait_st(mos_pkg::MOS_RUN);
    @(posedge clock_i);
    rdy <= 1'b0;
    flt <= 1'b1;
    wait_st(mos_pkg::MOS_ERROR);
    @(posedge clock_i);
    flt <= 1'b0;
    measure(mos_pkg::MOS_ERROR, 5);
    chk(st, mos_pkg::MOS_DETECT);
    @(posedge clock_i);
    fwd <= 1'b1;
    wait_st(mos_pkg::MOS_RUN);
    @(posedge clock_i);
    flt <= 1'b1;
    wait_st(mos_pkg::MOS_ERROR);
    go(8'h00);
    flt <= 1'b0;
    wait_st(mos_pkg::MOS_IDLE);
    go(8'hff);
    wait_st(mos_pkg::MOS_RUN);
    @(posedge clock_i);
    pin <= 1'b0;
    measure(mos_pkg::MOS_RUN, 101);
    chk({st, hiz, eclr}, {mos_pkg::MOS_SLEEP, 2'b11});
    setm(8'h13, 8'h38);
    go(8'h00);
    pin <= 1'b1;
    wait_st(mos_pkg::MOS_BRAKE);
    measure(mos_pkg::MOS_BRAKE, 1000);
    chk({st, drv}, {mos_pkg::MOS_HOLD, mos_pkg::MOS_DRV_BRAKE});
    go(8'h01);
    wait_st(mos_pkg::MOS_DETECT);
    go(8'h00);
    wait_st(mos_pkg::MOS_IDLE);
    @(posedge clock_i);
    wr <= 1'b1;
    addr <= 8'h0e;
    wdat <= 8'h80;
    @(posedge clock_i);
    wr <= 1'b0;
    mdl[8'h0e] = 8'h80;
    rd_reg(8'h0e);
    @(posedge clock_i);
    halt <= 1'b1;
    pin <= 1'b0;
    repeat (480) @(negedge clock_i);
    chk(st, mos_pkg::MOS_IDLE);
    @(posedge clock_i);
    halt <= 1'b0;
    measure(mos_pkg::MOS_IDLE, 101);
    chk(st, mos_pkg::MOS_SLEEP);
    // Reload a 0 s brake with hold set: hold is ignored and the gates stay off
    setm(8'h0e, 8'h00);
    setm(8'h13, 8'h08);
    setm(8'h14, 8'h11);
    setm(8'h15, 8'h03);
    @(posedge clock_i);
    pin <= 1'b1;
    fwd <= 1'b0;
    wait_st(mos_pkg::MOS_BRAKE);
    chk({drv, hiz}, {mos_pkg::MOS_DRV_OFF, 1'b1});
    wait_st(mos_pkg::MOS_IDLE);
    for (int i = 0; i < 6; i++) rd_reg(al[i]);
    chk(fcf, 2'h3);
    go(8'($urandom_range(255, 1)));
    wait_st(mos_pkg::MOS_DETECT);
    measure(mos_pkg::MOS_DETECT, 25);
    measure(mos_pkg::MOS_DC1, 500);
    measure(mos_pkg::MOS_DC2, 200);
    chk(st, mos_pkg::MOS_FORCED);
    report_and_stop();
  end
endmodule : tb_mos_sequencer
bind mos_sequencer mos_sequencer_assertions i_mos_sequencer_assertions (
  .clock_i(clock_i), .resetn_i(resetn_i), .sleep_request_pin_i(sleep_request_pin_i),
  .speed_cmd_i(speed_cmd_i), .fault_i(fault_i), .motor_forward_i(motor_forward_i),
  .nvm_req_o(nvm_req_o), .nvm_addr_o(nvm_addr_o), .nvm_ack_i(nvm_ack_i), .state_o(state_o),
  .drive_mode_o(drive_mode_o), .gates_hiz_o(gates_hiz_o), .error_clear_o(error_clear_o));
